// *** hw/sipl_pkg.sv ***
// shared constants for the serial-in parallel-out latch
package sipl_pkg;

  // shift chain and storage geometry
  localparam int unsigned SIPL_STAGES    = 8;
  localparam int unsigned SIPL_LAST      = SIPL_STAGES - 1;

  // synchroniser depth for pin inputs
  localparam int unsigned SIPL_SYNC_LEN  = 2;

  // pin vector bit positions into the synchroniser
  localparam int unsigned SIPL_PIN_SER   = 0;
  localparam int unsigned SIPL_PIN_SCLK  = 1;
  localparam int unsigned SIPL_PIN_RCLK  = 2;
  localparam int unsigned SIPL_PIN_CLRN  = 3;
  localparam int unsigned SIPL_PIN_OEN   = 4;
  localparam int unsigned SIPL_PIN_COUNT = 5;

  // reset values
  localparam logic [7:0] SIPL_CHAIN_RST = 8'h00;
  localparam logic [7:0] SIPL_STORE_RST = 8'h00;
  localparam logic [7:0] SIPL_OEN_RST   = 8'hFF;
  localparam logic [4:0] SIPL_PIN_RST   = 5'h18;
  localparam logic       SIPL_VLD_RST   = 1'h0;
  localparam logic       SIPL_RDY_RST   = 1'h1;

endpackage : sipl_pkg

// *** hw/sipl_sync.sv ***
// two-flop synchroniser with rising-edge detect behind it
`timescale 1ns/1ns
`default_nettype none
module sipl_sync
  import sipl_pkg::*;
#(
  parameter int unsigned     WIDTH   = SIPL_PIN_COUNT,
  parameter logic [WIDTH-1:0] RST_VAL = SIPL_PIN_RST
)
(
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // asynchronous pins
  input  wire logic [WIDTH-1:0] pin_async,
  // synchronised levels and edges
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] rise_nxt;

  // edge found only between second and third flop, never on meta_r
  assign rise_nxt = stable_r & ~prev_r;
  assign level    = stable_r;
  assign rise     = rise_nxt;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r   <= RST_VAL;
      stable_r <= RST_VAL;
      prev_r   <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r   <= pin_async;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

endmodule // sipl_sync
`default_nettype wire

// *** hw/sipl_top.sv ***
// shift chain, storage register, output enable and capture buffer
`timescale 1ns/1ns
`default_nettype none
module sipl_top
  import sipl_pkg::*;
#(
  parameter int unsigned STAGES = SIPL_STAGES
)
(
  // clock, reset, enable
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // controller pins
  input  wire logic              SERIAL_DATA_IN,
  input  wire logic              SHIFT_CLOCK,
  input  wire logic              STORAGE_CLOCK,
  input  wire logic              SHIFT_CLEAR_N,
  input  wire logic              OUTPUT_ENABLE_N,
  // parallel pins, three-state as value plus enable
  output logic      [STAGES-1:0] PARALLEL_OUTPUTS,
  output logic      [STAGES-1:0] PARALLEL_OE_N,
  // cascade pin
  output logic                   SERIAL_CASCADE_OUT,
  // captured word stream
  output logic      [STAGES-1:0] WORD_DATA,
  output logic                   WORD_VALID,
  input  wire logic              WORD_READY,
  output logic                   CAPTURE_READY
);

  // synchronised pin levels and edges
  logic [SIPL_PIN_COUNT-1:0] pin_level;
  logic [SIPL_PIN_COUNT-1:0] pin_rise;
  logic [SIPL_PIN_COUNT-1:0] pin_async;

  assign pin_async[SIPL_PIN_SER]  = SERIAL_DATA_IN;
  assign pin_async[SIPL_PIN_SCLK] = SHIFT_CLOCK;
  assign pin_async[SIPL_PIN_RCLK] = STORAGE_CLOCK;
  assign pin_async[SIPL_PIN_CLRN] = SHIFT_CLEAR_N;
  assign pin_async[SIPL_PIN_OEN]  = OUTPUT_ENABLE_N;

  sipl_sync #(
    .WIDTH   (SIPL_PIN_COUNT),
    .RST_VAL (SIPL_PIN_RST)
  ) u_sync (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .pin_async (pin_async),
    .level     (pin_level),
    .rise      (pin_rise)
  );

  // decoded pin events
  logic ser_bit;
  logic clear_act;
  logic shift_rise;
  logic store_rise;
  logic oe_n_level;

  // pins are sampled as data, never used as clocks, so one domain serves all
  // a pin pulse shorter than one clock may be missed, clear included
  assign ser_bit    = pin_level[SIPL_PIN_SER];
  assign clear_act  = ~pin_level[SIPL_PIN_CLRN];
  assign shift_rise = pin_rise[SIPL_PIN_SCLK];
  assign store_rise = pin_rise[SIPL_PIN_RCLK];
  assign oe_n_level = pin_level[SIPL_PIN_OEN];

  // shift chain
  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_shift;
  logic [STAGES-1:0] chain_nxt;

  // stage one takes data, later stages their neighbour's old value
  assign chain_shift[0] = ser_bit;

  genvar g;
  generate
    for (g = 1; g < STAGES; g++)
    begin : g_stage
      assign chain_shift[g] = chain_r[g-1];
    end
  endgenerate

  // clear is a level and beats any shift in the same cycle
  assign chain_nxt = clear_act  ? SIPL_CHAIN_RST[STAGES-1:0] :
                     shift_rise ? chain_shift                   :
                                  chain_r;

  always_ff @(posedge CLK)
  begin
    if (RST)
      chain_r <= SIPL_CHAIN_RST[STAGES-1:0];
    else if (CE)
      chain_r <= chain_nxt;
  end

  // storage register
  logic [STAGES-1:0] store_r;
  logic [STAGES-1:0] store_nxt;

  // reads chain_r, the value before any shift of this cycle
  assign store_nxt = store_rise ? chain_r : store_r;

  always_ff @(posedge CLK)
  begin
    if (RST)
      store_r <= SIPL_STORE_RST[STAGES-1:0];
    else if (CE)
      store_r <= store_nxt;
  end

  // pin drivers, registered so every output comes from a flop
  logic [STAGES-1:0] par_out_r;
  logic [STAGES-1:0] par_oe_n_r;
  logic              cascade_r;
  logic [STAGES-1:0] par_oe_n_nxt;

  // output enable only gates the pads, storage keeps its value
  assign par_oe_n_nxt = {STAGES{oe_n_level}};

  // pads are fed from the next values, so they move with the registers, not a clock later
  // cascade follows chain_nxt, so it moves on the same edge as stage eight
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      par_out_r  <= SIPL_STORE_RST[STAGES-1:0];
      par_oe_n_r <= SIPL_OEN_RST[STAGES-1:0];
      cascade_r  <= SIPL_CHAIN_RST[STAGES-1];
    end
    else if (CE)
    begin
      par_out_r  <= store_nxt;
      par_oe_n_r <= par_oe_n_nxt;
      cascade_r  <= chain_nxt[STAGES-1];
    end
  end

  assign PARALLEL_OUTPUTS   = par_out_r;
  assign PARALLEL_OE_N      = par_oe_n_r;
  assign SERIAL_CASCADE_OUT = cascade_r;

  // two-entry capture buffer: head feeds the port, spare absorbs a stall
  logic [STAGES-1:0] head_r;
  logic              head_vld_r;
  logic [STAGES-1:0] spare_r;
  logic              spare_vld_r;
  logic              cap_rdy_r;
  logic              pop;
  logic              push;
  logic              head_keep;
  logic              head_vld_nxt;
  logic [STAGES-1:0] head_nxt;
  logic              spare_hold;
  logic              spare_vld_nxt;
  logic [STAGES-1:0] spare_nxt;

  // a held word always wins over a fresh one, so order is kept
  function automatic logic [STAGES-1:0] keep_or(
    input logic              keep,
    input logic [STAGES-1:0] held,
    input logic [STAGES-1:0] fresh
  );
    return keep ? held : fresh;
  endfunction

  // a pop and a push may meet in one cycle
  // a word whose storage rise meets a full buffer is missing from the stream only
  assign pop       = head_vld_r & WORD_READY;
  assign push      = store_rise & ~spare_vld_r;
  assign head_keep = head_vld_r & ~pop;

  // fresh words come from chain_r, the same value the storage register takes
  assign head_vld_nxt  = head_keep | spare_vld_r | push;
  assign head_nxt      = keep_or(head_keep, head_r, keep_or(spare_vld_r, spare_r, chain_r));
  assign spare_hold    = spare_vld_r & head_keep;
  assign spare_vld_nxt = spare_hold | (push & (head_keep | spare_vld_r));
  assign spare_nxt     = keep_or(spare_hold, spare_r, chain_r);

  // ready is registered from the next spare state, so it never lags a push
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      head_r      <= SIPL_STORE_RST[STAGES-1:0];
      head_vld_r  <= SIPL_VLD_RST;
      spare_r     <= SIPL_STORE_RST[STAGES-1:0];
      spare_vld_r <= SIPL_VLD_RST;
      cap_rdy_r   <= SIPL_RDY_RST;
    end
    else if (CE)
    begin
      head_r      <= head_nxt;
      head_vld_r  <= head_vld_nxt;
      spare_r     <= spare_nxt;
      spare_vld_r <= spare_vld_nxt;
      cap_rdy_r   <= ~spare_vld_nxt;
    end
  end

  assign WORD_DATA     = head_r;
  assign WORD_VALID    = head_vld_r;
  assign CAPTURE_READY = cap_rdy_r;

endmodule // sipl_top
`default_nettype wire

// *** verification/sipl_top_asserts.sv ***
// port checker for the latch
`timescale 1ns/1ns
`default_nettype none
module sipl_top_asserts
  import sipl_pkg::*;
#(parameter int unsigned STAGES = SIPL_STAGES)
(
  // clock, reset, pins
  input wire logic CLK, RST, SHIFT_CLOCK, STORAGE_CLOCK, SHIFT_CLEAR_N, OUTPUT_ENABLE_N,
  // pads and stream
  input wire logic [STAGES-1:0] PARALLEL_OUTPUTS, PARALLEL_OE_N, WORD_DATA,
  input wire logic SERIAL_CASCADE_OUT, WORD_VALID, WORD_READY, CAPTURE_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // a pin level shows at the ports three clocks after it is sampled
  property p_oe; PARALLEL_OE_N == {STAGES{$past(OUTPUT_ENABLE_N, 3)}}; endproperty
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  property p_hold; $stable(PARALLEL_OUTPUTS) || ($past(STORAGE_CLOCK, 3) && !$past(STORAGE_CLOCK, 4)); endproperty
  a_hold: assert property (p_hold) else $error("storage moved without rise");
  property p_pre; $rose(STORAGE_CLOCK) |-> ##3 PARALLEL_OUTPUTS[STAGES-1] == $past(SERIAL_CASCADE_OUT); endproperty
  a_pre: assert property (p_pre) else $error("storage not chain copy");
  property p_casc;
    $stable(SERIAL_CASCADE_OUT) || ($past(SHIFT_CLOCK, 3) && !$past(SHIFT_CLOCK, 4)) || !$past(SHIFT_CLEAR_N, 3);
  endproperty
  a_casc: assert property (p_casc) else $error("cascade moved without cause");
  property p_clr; !SHIFT_CLEAR_N |-> ##3 !SERIAL_CASCADE_OUT; endproperty
  a_clr: assert property (p_clr) else $error("clear left a stage set");
  property p_whold; WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA); endproperty
  a_whold: assert property (p_whold) else $error("stalled word lost");
  property p_push; $rose(STORAGE_CLOCK) |-> ##3 WORD_VALID; endproperty
  a_push: assert property (p_push) else $error("captured word missing");
  property p_room; !WORD_VALID |-> CAPTURE_READY; endproperty
  a_room: assert property (p_room) else $error("empty buffer refuses");
endmodule // sipl_top_asserts
bind sipl_top sipl_top_asserts #(.STAGES(STAGES)) sipl_top_asserts_i (.CLK(CLK), .RST(RST),
  .SHIFT_CLOCK(SHIFT_CLOCK), .STORAGE_CLOCK(STORAGE_CLOCK), .SHIFT_CLEAR_N(SHIFT_CLEAR_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .PARALLEL_OUTPUTS(PARALLEL_OUTPUTS), .PARALLEL_OE_N(PARALLEL_OE_N),
  .WORD_DATA(WORD_DATA), .SERIAL_CASCADE_OUT(SERIAL_CASCADE_OUT), .WORD_VALID(WORD_VALID),
  .WORD_READY(WORD_READY), .CAPTURE_READY(CAPTURE_READY));
`default_nettype wire

// *** verification/sipl_ctrl_model.sv ***
// controller model driving data, clocks and clear
`timescale 1ns/1ns
`default_nettype none
module sipl_ctrl_model
(
  // controller pins
  output logic serial_data_in,
  output logic sclk,
  output logic rclk,
  output logic clr_n
);
  initial {serial_data_in, sclk, rclk, clr_n} = 4'h1;
  // msb first, so the first bit ends in stage eight
  task automatic send(input logic [7:0] b, input logic tied);
    for (int i = 7; i >= 0; i--)
    begin
      serial_data_in = b[i];
      #40;
      sclk = 1'b1;
      rclk = tied;
      #40;
      sclk = 1'b0;
      rclk = 1'b0;
    end
    // a stale level would pass for data
    serial_data_in = ~serial_data_in;
  endtask
  task automatic store;
    rclk = 1'b1;
    #40;
    rclk = 1'b0;
    #40;
  endtask
  task automatic clear;
    clr_n = 1'b0;
    #40;
    clr_n = 1'b1;
    #40;
  endtask
endmodule // sipl_ctrl_model
`default_nettype wire

// *** verification/sipl_top_tb.sv ***
// self-checking bench for the latch
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sipl_top_tb;
  logic       clk = 0, rst = 1, ce = 1, oe_n = 1, rdy = 0;
  logic       serial_data_in, sclk, rclk, clr_n, casc, wv, cap_rdy;
  logic [7:0] q, q_oe_n, wd;
  int         failures = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  sipl_ctrl_model sipl_ctrl_model_i (.serial_data_in(serial_data_in), .sclk(sclk), .rclk(rclk), .clr_n(clr_n));
  sipl_top sipl_top_i (.CLK(clk), .RST(rst), .CE(ce), .SERIAL_DATA_IN(serial_data_in), .SHIFT_CLOCK(sclk),
    .STORAGE_CLOCK(rclk), .SHIFT_CLEAR_N(clr_n), .OUTPUT_ENABLE_N(oe_n), .PARALLEL_OUTPUTS(q),
    .PARALLEL_OE_N(q_oe_n), .SERIAL_CASCADE_OUT(casc), .WORD_DATA(wd), .WORD_VALID(wv),
    .WORD_READY(rdy), .CAPTURE_READY(cap_rdy));
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_byte;
    oe_n = 0;
    sipl_ctrl_model_i.send(8'hA5, 0);
    settle;
    `CHK({casc, q}, 9'h100)
    sipl_ctrl_model_i.store;
    settle;
    `CHK({q_oe_n, q}, 16'h00A5)
    oe_n = 1;
    settle;
    `CHK({q_oe_n, q}, 16'hFFA5)
  endtask
  task automatic t_clear;
    sipl_ctrl_model_i.clear;
    settle;
    `CHK({casc, q}, 9'h0A5)
    sipl_ctrl_model_i.store;
    settle;
    `CHK(q, 8'h00)
  endtask
  // one shared clock: storage lags the chain by a pulse, buffer full so nothing queued
  task automatic t_tied;
    sipl_ctrl_model_i.send(8'h3C, 1);
    settle;
    `CHK({cap_rdy, q}, 9'h01E)
  endtask
  // clock enable low: pin activity while frozen leaves no trace
  task automatic t_freeze;
    ce = 0;
    sipl_ctrl_model_i.send(8'hFF, 1);
    ce = 1;
    settle;
    `CHK({casc, q}, 9'h01E)
  endtask
  task automatic pop(input logic [7:0] exp);
    int n = 0;
    while (wv !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    `CHK({wv, wd}, {1'b1, exp})
    rdy = 1;
    @(negedge clk);
    rdy = 0;
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 0;
    `CHK({q_oe_n, q, casc, wv, cap_rdy}, 19'h7_F801)
    t_byte;
    t_clear;
    t_tied;
    t_freeze;
    pop(8'hA5);
    pop(8'h00);
    @(negedge clk);
    `CHK({wv, cap_rdy}, 2'h1)
    finish_test;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      finish_test;
    end
  end
endmodule // sipl_top_tb
`default_nettype wire
